// ---- epi_change_det.sv ----
// edge and toggle detector on synchronised levels
// assumes the input already passed a synchroniser; arms after the chain fills
`timescale 1ns/10ps
module epi_change_det #(
    parameter int unsigned W = 8
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_b,
    // levels and events
    input  wire logic [W-1:0] level,
    output logic              armed,
    output logic      [W-1:0] toggled,
    output logic      [W-1:0] rose,
    output logic      [W-1:0] fell
);
    logic [W-1:0] prev_ff;
    logic [2:0]   fill_ff;

    // arming hides the fake change from reset zeros in the chain
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            prev_ff <= '0;
            fill_ff <= 3'h0;
        end else begin
            prev_ff <= level;
            fill_ff <= {fill_ff[1:0], 1'b1};
        end
    end

    assign armed   = fill_ff[2];
    assign toggled = armed ? (level ^ prev_ff) : '0;
    assign rose    = toggled & level;
    assign fell    = toggled & ~level;
endmodule // epi_change_det

// ---- epi_core.sv ----
// external pin interrupt block: dedicated pin, two pin-change groups,
// flags, enables, request and vector to the core, wake and clock gating
// assumes core strobes, gie, ack and sleep state are on clock
//
// Notes on behaviour
// - group zero requests on toggles of enabled pins 0-7, group one on 8-15
// - pad levels are sensed even when the pins drive as outputs
// - pin changes on all sixteen inputs can wake the part from deep sleep
// - sense field: 00 low, 01 any change, 10 falling, 11 rising
// - level mode with enable keeps requesting while the pin stays low
// - dedicated low level and edges can wake the part from deep sleep
// - io clock runs only when active or idle
// - wake persists if the level vanishes; then no request is made
// - dedicated request needs enable bit 6 and global enable
// - group one uses enable bit 5, group zero bit 4, both need gie
// - a per-pin mask bit counts only while its group enable is set
// - flag 6 set by dedicated edge; cleared by vector ack or writing one
// - dedicated flag is held zero in level sense mode
// - flags 5 and 4 set on group change; cleared by ack or writing one
// - set flag with its enable and gie branches to its vector
// - bits 7 and 3:0 of enable and flag registers read zero
// - vectors: dedicated 0x0001, group zero 0x0002, group one 0x0003
`timescale 1ns/10ps
module epi_core
    import epi_pkg::*;
(
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst_b,
    // register port
    input  wire epi_pkg::epi_bus_req_t bus_req,
    output logic [epi_pkg::EPI_DW-1:0] bus_rdata,
    // pads
    input  wire logic                 dedicated_irq_pin,
    input  wire logic [15:0]          pin_change_input,
    // core side
    input  wire logic                 gie,
    input  wire epi_pkg::epi_src_t    vec_ack,
    input  wire epi_pkg::epi_sleep_t  sleep_mode,
    output epi_pkg::epi_src_t         irq_req,
    output logic [15:0]               irq_vector,
    output logic                      wake_req,
    output logic                      io_clk_run
);
    import epi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pad synchronisation and change detection
    logic [16:0] pad_sync;
    logic        armed;
    logic [16:0] pad_tog;
    logic [16:0] pad_rise;
    logic [16:0] pad_fall;

    // pad levels, not port registers, so output pins still trigger
    epi_sync #(.W(17)) u_sync (
        .clock    (clock),
        .rst_b    (rst_b),
        .async_in ({dedicated_irq_pin, pin_change_input}),
        .sync_out (pad_sync)
    );

    epi_change_det #(.W(17)) u_det (
        .clock   (clock),
        .rst_b   (rst_b),
        .level   (pad_sync),
        .armed   (armed),
        .toggled (pad_tog),
        .rose    (pad_rise),
        .fell    (pad_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  mask_low_ff;
    logic [7:0]  mask_high_ff;
    logic [2:0]  enable_ff;
    epi_sense_t  sense_ff;
    epi_src_t    flag_ff;
    epi_src_t    req_ff;
    logic [15:0] vec_ff;
    logic [7:0]  rdata_ff;
    logic        wake_ff;

    function automatic logic group_hit(input logic [7:0] tog,
                                       input logic [7:0] mask,
                                       input logic       en);
        group_hit = en & |(tog & mask);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire wr_mlow  = bus_req.wr && bus_req.addr == EPI_OFS_MASK_LOW;
    wire wr_mhigh = bus_req.wr && bus_req.addr == EPI_OFS_MASK_HIGH;
    wire wr_en    = bus_req.wr && bus_req.addr == EPI_OFS_ENABLE;
    wire wr_sense = bus_req.wr && bus_req.addr == EPI_OFS_SENSE;
    wire wr_flags = bus_req.wr && bus_req.addr == EPI_OFS_FLAGS;

    wire en_ded  = enable_ff[2];
    wire en_grp1 = enable_ff[1];
    wire en_grp0 = enable_ff[0];

    wire [2:0] nxt_enable = wr_en ? {bus_req.wdata[EPI_BIT_DED],
                                     bus_req.wdata[EPI_BIT_GRP1],
                                     bus_req.wdata[EPI_BIT_GRP0]} : enable_ff;

    wire epi_sense_t nxt_sense = wr_sense ?
        epi_sense_t'({bus_req.wdata[EPI_BIT_SHI], bus_req.wdata[EPI_BIT_SLO]})
        : sense_ff;

    ////////////////////////////////////////////////////////////////////////////
    // event detection
    wire ded_level = pad_sync[16];
    wire ded_low   = armed & ~ded_level;

    // mask bit only counts with group enable
    wire hit_grp0 = group_hit(pad_tog[7:0], mask_low_ff, en_grp0);
    wire hit_grp1 = group_hit(pad_tog[15:8], mask_high_ff, en_grp1);

    logic hit_ded;
    always_comb begin
        unique case (sense_ff)
            EPI_SENSE_LOW:  hit_ded = 1'b0;
            EPI_SENSE_ANY:  hit_ded = pad_tog[16];
            EPI_SENSE_FALL: hit_ded = pad_fall[16];
            EPI_SENSE_RISE: hit_ded = pad_rise[16];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // flags: write one or ack clears, a hit in the same cycle wins
    wire clr_ded  = (wr_flags & bus_req.wdata[EPI_BIT_DED])  | vec_ack.ded;
    wire clr_grp1 = (wr_flags & bus_req.wdata[EPI_BIT_GRP1]) | vec_ack.grp1;
    wire clr_grp0 = (wr_flags & bus_req.wdata[EPI_BIT_GRP0]) | vec_ack.grp0;

    // level mode forces zero at once, including the cycle of the sense write
    wire nxt_flag_ded = (nxt_sense == EPI_SENSE_LOW) ? 1'b0 :
                        (hit_ded | (flag_ff.ded & ~clr_ded));
    wire nxt_flag_grp1 = hit_grp1 | (flag_ff.grp1 & ~clr_grp1);
    wire nxt_flag_grp0 = hit_grp0 | (flag_ff.grp0 & ~clr_grp0);

    ////////////////////////////////////////////////////////////////////////////
    // requests to the core and vector selection
    // level request follows the pin; if it goes away no request is made
    wire ded_src = (sense_ff == EPI_SENSE_LOW) ? ded_low : flag_ff.ded;
    wire nxt_req_ded  = gie & en_ded & ded_src;
    wire nxt_req_grp0 = gie & en_grp0 & flag_ff.grp0;
    wire nxt_req_grp1 = gie & en_grp1 & flag_ff.grp1;

    // lowest address wins, like the core's fixed priority
    wire [15:0] nxt_vec = nxt_req_ded  ? EPI_VEC_DED  :
                          nxt_req_grp0 ? EPI_VEC_GRP0 :
                          nxt_req_grp1 ? EPI_VEC_GRP1 : EPI_VEC_NONE;

    ////////////////////////////////////////////////////////////////////////////
    // sleep: io clock gating and wake
    wire deep_sleep = (sleep_mode == EPI_SLP_ADCNR) || (sleep_mode == EPI_SLP_PDOWN);
    wire nxt_io_run = ~deep_sleep;

    // detection runs on clock, which stays alive while io clock is halted
    // a low pin wakes only in level mode; edge modes wait for their edge
    wire wake_hit = (en_ded & (hit_ded | ((sense_ff == EPI_SENSE_LOW) & ded_low)))
                  | hit_grp0 | hit_grp1;
    // wake sticks until the core is active again, even if the level left
    wire nxt_wake = (sleep_mode == EPI_SLP_ACTIVE) ? 1'b0 :
                    (wake_ff | (deep_sleep & wake_hit));

    ////////////////////////////////////////////////////////////////////////////
    // read mux; reserved bits fixed at zero
    wire [7:0] rd_enable = {1'b0, en_ded, en_grp1, en_grp0, 4'h0};
    wire [7:0] rd_flags  = {1'b0, flag_ff.ded, flag_ff.grp1,
                            flag_ff.grp0, 4'h0};
    wire [7:0] rd_sense  = {6'h00, sense_ff};

    wire [7:0] rd_mux = (bus_req.addr == EPI_OFS_MASK_LOW)  ? mask_low_ff  :
                        (bus_req.addr == EPI_OFS_MASK_HIGH) ? mask_high_ff :
                        (bus_req.addr == EPI_OFS_ENABLE)    ? rd_enable    :
                        (bus_req.addr == EPI_OFS_FLAGS)     ? rd_flags     :
                        (bus_req.addr == EPI_OFS_SENSE)     ? rd_sense     : 8'h00;

    wire [7:0] nxt_rdata = bus_req.rd ? rd_mux : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // state
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mask_low_ff  <= EPI_RST_MASK;
            mask_high_ff <= EPI_RST_MASK;
            enable_ff    <= EPI_RST_ENABLE[EPI_BIT_DED:EPI_BIT_GRP0];
            sense_ff     <= epi_sense_t'(EPI_RST_SENSE);
        end else begin
            if (wr_mlow) begin
                mask_low_ff <= bus_req.wdata;
            end
            if (wr_mhigh) begin
                mask_high_ff <= bus_req.wdata;
            end
            enable_ff <= nxt_enable;
            sense_ff  <= nxt_sense;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            flag_ff  <= '0;
            req_ff   <= '0;
            vec_ff   <= EPI_VEC_NONE;
            rdata_ff <= 8'h00;
            wake_ff  <= 1'b0;
        end else begin
            flag_ff  <= '{grp1: nxt_flag_grp1, grp0: nxt_flag_grp0, ded: nxt_flag_ded};
            req_ff   <= '{grp1: nxt_req_grp1, grp0: nxt_req_grp0, ded: nxt_req_ded};
            vec_ff   <= nxt_vec;
            rdata_ff <= nxt_rdata;
            wake_ff  <= nxt_wake;
        end
    end

    logic io_run_ff;
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            io_run_ff <= 1'b1;
        end else begin
            io_run_ff <= nxt_io_run;
        end
    end

    assign bus_rdata  = rdata_ff;
    assign irq_req    = req_ff;
    assign irq_vector = vec_ff;
    assign wake_req   = wake_ff;
    assign io_clk_run = io_run_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    level_flag_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
        sense_ff == EPI_SENSE_LOW |-> !flag_ff.ded)
        else $error("dedicated flag set in level mode");

    group0_set_a: assert property (@(posedge clock) disable iff (!rst_b)
        (armed && en_grp0 && |(pad_tog[7:0] & mask_low_ff)) |=> flag_ff.grp0)
        else $error("group zero change did not set flag");

    group1_mask_a: assert property (@(posedge clock) disable iff (!rst_b)
        (!flag_ff.grp1 && !en_grp1) |=> !flag_ff.grp1)
        else $error("group one flag set while group disabled");

    set_wins_a: assert property (@(posedge clock) disable iff (!rst_b)
        (hit_grp1 && clr_grp1) |=> flag_ff.grp1)
        else $error("change lost against a clear");

    flag_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
        (vec_ack.grp0 && !hit_grp0) |=> !flag_ff.grp0)
        else $error("group zero flag not cleared by ack");

    ded_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
        (wr_flags && bus_req.wdata[EPI_BIT_DED] && !hit_ded) |=> !flag_ff.ded)
        else $error("dedicated flag not cleared by write one");

    fall_edge_a: assert property (@(posedge clock) disable iff (!rst_b)
        (sense_ff == EPI_SENSE_FALL && !wr_sense && $fell(pad_sync[16]) && armed)
        |=> flag_ff.ded)
        else $error("falling edge missed");

    level_req_a: assert property (@(posedge clock) disable iff (!rst_b)
        (sense_ff == EPI_SENSE_LOW && gie && en_ded && ded_low)[*2] |-> req_ff.ded)
        else $error("level request not held while pin low");

    req_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
        !gie |=> (req_ff == '0 && vec_ff == EPI_VEC_NONE))
        else $error("request raised without global enable");

    vector_a: assert property (@(posedge clock) disable iff (!rst_b)
        req_ff.ded |-> vec_ff == EPI_VEC_DED)
        else $error("wrong vector for dedicated request");

    reserved_a: assert property (@(posedge clock) disable iff (!rst_b)
        (bus_req.rd && (bus_req.addr == EPI_OFS_ENABLE || bus_req.addr == EPI_OFS_FLAGS))
        |=> (bus_rdata[7] == 1'b0 && bus_rdata[3:0] == 4'h0))
        else $error("reserved bits read non-zero");

    io_clock_a: assert property (@(posedge clock) disable iff (!rst_b)
        deep_sleep |=> !io_clk_run)
        else $error("io clock running in deep sleep");

    group_wake_a: assert property (@(posedge clock) disable iff (!rst_b)
        (deep_sleep && (hit_grp0 || hit_grp1)) |=> wake_req)
        else $error("pin change did not wake");

    level_wake_a: assert property (@(posedge clock) disable iff (!rst_b)
        (deep_sleep && en_ded && sense_ff == EPI_SENSE_LOW && ded_low) |=> wake_req)
        else $error("low level did not wake");

    wake_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
        (wake_req && sleep_mode != EPI_SLP_ACTIVE) |=> wake_req)
        else $error("wake dropped before core active");
endmodule // epi_core

// ---- epi_pad_model.sv ----
// pad and core model for the external pin interrupt block
// assumes the bench moves pads through its tasks and sets ack_en
`timescale 1ns/10ps
module epi_pad_model (
    // clock
    input  wire logic              clock,
    // core side
    input  wire logic              ack_en,
    input  wire epi_pkg::epi_src_t irq_req,
    output epi_pkg::epi_src_t      vec_ack,
    // pads
    output logic                   dedicated_irq_pin,
    output logic [15:0]            pin_change_input
);
    import epi_pkg::*;

    epi_src_t pick;

    initial begin
        dedicated_irq_pin = 1'b1;
        pin_change_input = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // core executes the lowest vector first, one ack pulse every other cycle while a request stands
    assign pick = irq_req.ded  ? epi_src_t'(3'h1) :
                  irq_req.grp0 ? epi_src_t'(3'h2) :
                  irq_req.grp1 ? epi_src_t'(3'h4) : epi_src_t'(3'h0);

    always @(posedge clock) begin
        vec_ack <= (ack_en && vec_ack == '0) ? pick : '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pads driven as outputs by the part itself still count as activity
    task automatic toggle(input int n);
        @(posedge clock);
        if (n == 16) begin
            dedicated_irq_pin <= ~dedicated_irq_pin;
        end else begin
            pin_change_input[n] <= ~pin_change_input[n];
        end
    endtask

    // a low level stays until the bench lifts it, past wake-up and the
    // current instruction; lifting early is a deliberate scenario
    task automatic set_ded(input logic v);
        @(posedge clock);
        dedicated_irq_pin <= v;
    endtask
endmodule // epi_pad_model

// ---- epi_pkg.sv ----
// constants, types and register map for the external pin interrupt block
// assumes one system clock; the core and software sit on that clock
package epi_pkg;

    localparam int unsigned EPI_AW         = 8;
    localparam int unsigned EPI_DW         = 8;
    localparam int unsigned EPI_GRP_W      = 8;
    localparam int unsigned EPI_SYNC_DEPTH = 2;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] EPI_OFS_MASK_LOW  = 8'h12;
    localparam logic [7:0] EPI_OFS_MASK_HIGH = 8'h20;
    localparam logic [7:0] EPI_OFS_ENABLE    = 8'h3b;
    localparam logic [7:0] EPI_OFS_SENSE     = 8'h35;
    localparam logic [7:0] EPI_OFS_FLAGS     = 8'h3a;

    // reset values
    localparam logic [7:0] EPI_RST_MASK   = 8'h00;
    localparam logic [7:0] EPI_RST_ENABLE = 8'h00;
    localparam logic [1:0] EPI_RST_SENSE  = 2'h0;

    // field positions in enable, flag and sense registers
    localparam int unsigned EPI_BIT_DED  = 6;
    localparam int unsigned EPI_BIT_GRP1 = 5;
    localparam int unsigned EPI_BIT_GRP0 = 4;
    localparam int unsigned EPI_BIT_SLO  = 0;
    localparam int unsigned EPI_BIT_SHI  = 1;

    // vector addresses
    localparam logic [15:0] EPI_VEC_NONE = 16'h0000;
    localparam logic [15:0] EPI_VEC_DED  = 16'h0001;
    localparam logic [15:0] EPI_VEC_GRP0 = 16'h0002;
    localparam logic [15:0] EPI_VEC_GRP1 = 16'h0003;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        EPI_SENSE_LOW  = 2'b00,
        EPI_SENSE_ANY  = 2'b01,
        EPI_SENSE_FALL = 2'b10,
        EPI_SENSE_RISE = 2'b11
    } epi_sense_t;

    typedef enum logic [1:0] {
        EPI_SLP_ACTIVE = 2'b00,
        EPI_SLP_IDLE   = 2'b01,
        EPI_SLP_ADCNR  = 2'b10,
        EPI_SLP_PDOWN  = 2'b11
    } epi_sleep_t;

    typedef struct packed {
        logic grp1;
        logic grp0;
        logic ded;
    } epi_src_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } epi_bus_req_t;

endpackage

// ---- epi_sync.sv ----
// two-flop synchroniser for a vector of pad levels
// assumes the pads are asynchronous to clock
`timescale 1ns/10ps
module epi_sync #(
    parameter int unsigned W = 8
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_b,
    // levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // first stage is read only by the second
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule // epi_sync

// ---- tb_epi_core.sv ----
// self-checking bench for the external pin interrupt block
// assumes epi_pad_model stands for the pads and the core
`timescale 1ns/10ps
module tb_epi_core;
    import epi_pkg::*;

    logic         clock;
    logic         rst_b;
    epi_bus_req_t bus_req;
    logic [7:0]   bus_rdata;
    logic         dedicated_irq_pin;
    logic [15:0]  pin_change_input;
    logic         gie;
    logic         ack_en;
    epi_src_t     vec_ack;
    epi_src_t     irq_req;
    epi_sleep_t   sleep_mode;
    logic [15:0]  irq_vector;
    logic         wake_req;
    logic         io_clk_run;
    int           bad_count;
    int           cmp_count;
    int           cycles;

    epi_core epi_core_inst (.clock(clock), .rst_b(rst_b), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .dedicated_irq_pin(dedicated_irq_pin),
        .pin_change_input(pin_change_input), .gie(gie), .vec_ack(vec_ack),
        .sleep_mode(sleep_mode), .irq_req(irq_req), .irq_vector(irq_vector),
        .wake_req(wake_req), .io_clk_run(io_clk_run));

    epi_pad_model epi_pad_model_inst (.clock(clock), .ack_en(ack_en),
        .irq_req(irq_req), .vec_ack(vec_ack),
        .dedicated_irq_pin(dedicated_irq_pin),
        .pin_change_input(pin_change_input));

    always #4 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // hang guard: the whole run needs well under this
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // returns just after the edge so registered outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic set_core(input logic g, input epi_sleep_t m, input logic a);
        @(posedge clock);
        gie        <= g;
        sleep_mode <= m;
        ack_en     <= a;
    endtask

    // n edges with reset low, release on edge n+1
    task automatic reset_for(input int n);
        for (int i = n; i >= 0; i--) begin
            @(posedge clock);
            rst_b <= (i == 0);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus_req <= '0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus_req <= '0;
        #1;
        chk({8'h00, bus_rdata}, {8'h00, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(EPI_OFS_ENABLE, 8'h00);
        rd(EPI_OFS_FLAGS, 8'h00);
        rd(EPI_OFS_MASK_LOW, 8'h00);
        rd(EPI_OFS_MASK_HIGH, 8'h00);
        chk({15'h0, io_clk_run}, 16'h0001);
        wr(EPI_OFS_MASK_LOW, 8'ha5);
        wr(EPI_OFS_MASK_HIGH, 8'h5a);
        wr(EPI_OFS_ENABLE, 8'hff);
        wr(EPI_OFS_SENSE, 8'hff);
        wr(EPI_OFS_FLAGS, 8'hff);
        wr(8'h00, 8'hff);
        rd(EPI_OFS_MASK_LOW, 8'ha5);
        rd(EPI_OFS_MASK_HIGH, 8'h5a);
        rd(EPI_OFS_ENABLE, 8'h70);
        rd(EPI_OFS_SENSE, 8'h03);
        rd(EPI_OFS_FLAGS, 8'h00);
        rd(8'h00, 8'h00);
        wr(EPI_OFS_ENABLE, 8'h00);
        wr(EPI_OFS_SENSE, 8'h00);
    endtask

    task automatic t_groups();
        set_core(1'b1, EPI_SLP_ACTIVE, 1'b0);
        wr(EPI_OFS_MASK_LOW, 8'h08);
        wr(EPI_OFS_MASK_HIGH, 8'h80);
        wr(EPI_OFS_ENABLE, 8'h30);
        epi_pad_model_inst.toggle(2);
        cyc(6);
        rd(EPI_OFS_FLAGS, 8'h00);
        epi_pad_model_inst.toggle(3);
        epi_pad_model_inst.toggle(15);
        cyc(6);
        rd(EPI_OFS_FLAGS, 8'h30);
        chk({13'h0, irq_req}, 16'h0006);
        chk(irq_vector, EPI_VEC_GRP0);
        wr(EPI_OFS_FLAGS, 8'h10);
        cyc(2);
        chk(irq_vector, EPI_VEC_GRP1);
        set_core(1'b1, EPI_SLP_ACTIVE, 1'b1);
        cyc(6);
        rd(EPI_OFS_FLAGS, 8'h00);
        chk({13'h0, irq_req}, 16'h0000);
        // group zero taken and acked on its own vector
        epi_pad_model_inst.toggle(3);
        cyc(4);
        chk(irq_vector, EPI_VEC_GRP0);
        cyc(4);
        rd(EPI_OFS_FLAGS, 8'h00);
        wr(EPI_OFS_ENABLE, 8'h00);
        epi_pad_model_inst.toggle(3);
        cyc(6);
        rd(EPI_OFS_FLAGS, 8'h00);
        set_core(1'b1, EPI_SLP_ACTIVE, 1'b0);
        // change lands in the same cycle as a write-one clear
        wr(EPI_OFS_ENABLE, 8'h20);
        epi_pad_model_inst.toggle(15);
        cyc(1);
        wr(EPI_OFS_FLAGS, 8'h20);
        cyc(2);
        rd(EPI_OFS_FLAGS, 8'h20);
        wr(EPI_OFS_FLAGS, 8'h20);
        wr(EPI_OFS_ENABLE, 8'h00);
    endtask

    task automatic t_dedicated();
        wr(EPI_OFS_ENABLE, 8'h40);
        for (int s = 1; s < 4; s++) begin
            wr(EPI_OFS_SENSE, 8'(s));
            wr(EPI_OFS_FLAGS, 8'h40);
            epi_pad_model_inst.set_ded(1'b0);
            cyc(6);
            rd(EPI_OFS_FLAGS, (s != 3) ? 8'h40 : 8'h00);
            chk({15'h0, irq_req.ded}, 16'((s != 3)));
            wr(EPI_OFS_FLAGS, 8'h40);
            rd(EPI_OFS_FLAGS, 8'h00);
            epi_pad_model_inst.set_ded(1'b1);
            cyc(6);
            rd(EPI_OFS_FLAGS, (s != 2) ? 8'h40 : 8'h00);
        end
        chk(irq_vector, EPI_VEC_DED);
        wr(EPI_OFS_SENSE, 8'h00);
        rd(EPI_OFS_FLAGS, 8'h00);
        epi_pad_model_inst.set_ded(1'b0);
        cyc(6);
        chk({15'h0, irq_req.ded}, 16'h0001);
        rd(EPI_OFS_FLAGS, 8'h00);
        set_core(1'b0, EPI_SLP_ACTIVE, 1'b0);
        cyc(3);
        chk({15'h0, irq_req.ded}, 16'h0000);
        set_core(1'b1, EPI_SLP_ACTIVE, 1'b0);
        epi_pad_model_inst.set_ded(1'b1);
        cyc(6);
        chk({15'h0, irq_req.ded}, 16'h0000);
    endtask

    task automatic t_sleep();
        set_core(1'b0, EPI_SLP_PDOWN, 1'b0);
        wr(EPI_OFS_ENABLE, 8'h10);
        wr(EPI_OFS_MASK_LOW, 8'h01);
        cyc(1);
        chk({14'h0, io_clk_run, wake_req}, 16'h0000);
        epi_pad_model_inst.toggle(0);
        cyc(6);
        chk({14'h0, wake_req, irq_req.grp0}, 16'h0002);
        set_core(1'b0, EPI_SLP_ACTIVE, 1'b0);
        cyc(3);
        chk({14'h0, io_clk_run, wake_req}, 16'h0002);
        wr(EPI_OFS_FLAGS, 8'h70);
        wr(EPI_OFS_ENABLE, 8'h40);
        set_core(1'b1, EPI_SLP_ADCNR, 1'b0);
        epi_pad_model_inst.set_ded(1'b0);
        cyc(6);
        chk({15'h0, wake_req}, 16'h0001);
        epi_pad_model_inst.set_ded(1'b1);
        cyc(6);
        chk({14'h0, wake_req, irq_req.ded}, 16'h0002);
        set_core(1'b1, EPI_SLP_IDLE, 1'b0);
        cyc(3);
        chk({14'h0, io_clk_run, wake_req}, 16'h0003);
    endtask

    // mid-run reset brings registers and outputs back to zero, except io_clk_run which comes back to one
    task automatic t_reset();
        wr(EPI_OFS_SENSE, 8'h02);
        reset_for(2);
        cyc(1);
        chk({11'h0, io_clk_run, wake_req, irq_req}, 16'h0010);
        chk(irq_vector, EPI_VEC_NONE);
        rd(EPI_OFS_ENABLE, 8'h00);
        rd(EPI_OFS_SENSE, 8'h00);
        rd(EPI_OFS_MASK_LOW, 8'h00);
        rd(EPI_OFS_MASK_HIGH, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        bus_req = '0;
        gie = 1'b0;
        ack_en = 1'b0;
        sleep_mode = EPI_SLP_ACTIVE;
        bad_count = 0;
        cmp_count = 0;
        cycles = 0;
        reset_for(3);
        t_regs();
        t_groups();
        t_dedicated();
        t_sleep();
        t_reset();
        stop_test();
    end
endmodule // tb_epi_core
